// ### pke_defs.svh
// Register map, field positions and reset values of the key engine front end
`ifndef PKE_DEFS_SVH
`define PKE_DEFS_SVH

`define PKE_ADDR_CONFIG 32'h50006000
`define PKE_ADDR_COMMAND 32'h50006004
`define PKE_ADDR_CONTROL 32'h50006008
`define PKE_ADDR_STATUS 32'h5000600c
`define PKE_ADDR_VERSION 32'h50006010
`define PKE_ADDR_IRQ_STAT 32'h50006014
`define PKE_ADDR_IRQ_MASK 32'h50006018

`define PKE_CFG_PTR_A_LSB 0
`define PKE_CFG_PTR_B_LSB 8
`define PKE_CFG_PTR_C_LSB 16
`define PKE_CMD_RECOMP_BIT 31
`define PKE_CMD_SIGN_B_BIT 30
`define PKE_CMD_SIGN_A_BIT 29
`define PKE_CMD_SIZE_LSB 8
`define PKE_CMD_FIELD_BIT 7
`define PKE_CMD_OP_LSB 0
`define PKE_CTRL_START_BIT 0
`define PKE_STAT_BUSY_BIT 16
`define PKE_STAT_NOTINV_BIT 11

`define PKE_IRQ_DONE_BIT 0
`define PKE_IRQ_NOTINV_BIT 1
`define PKE_IRQ_REFUSED_BIT 2
`define PKE_IRQ_WIDTH 3

`define PKE_RESET_WORD 32'h00000000
// Arbitrary value, no meaning beyond identifying this build
`define PKE_VERSION_VALUE 32'h00010000
// Largest operand in 64-bit double words
`define PKE_MAX_DWORDS 8'h04

`define PKE_OPC_ADD 4'h1
`define PKE_OPC_SUB 4'h2
`define PKE_OPC_INV_ODD 4'h6
`define PKE_OPC_INV_EVEN 4'h9

`endif

// ### pke_pkg.sv
// Types shared by the key engine front end and its decoder
package pke_pkg;

  typedef enum logic [1:0] {
    PKE_OP_OTHER,
    PKE_OP_ADD,
    PKE_OP_SUB,
    PKE_OP_INV
  } pke_op_t;

  typedef struct packed {
    logic recompute_r_mod_n;
    logic coef_b_negative;
    logic coef_a_negative;
    logic [7:0] operand_size_dwords;
    logic binary_field;
    logic [6:0] operation_code;
    logic [4:0] operand_a_pointer;
    logic [4:0] operand_b_pointer;
    logic [4:0] result_pointer;
  } pke_cfg_t;

endpackage

// ### pke_op_decode.sv
// Operation code and operand size decoder of the key engine
`include "pke_defs.svh"

module pke_op_decode
  import pke_pkg::*;
(
  input wire logic [6:0] opcode_i,
  input wire logic [7:0] size_i,
  output pke_op_t op_o,
  output logic size_ok_o
);

  always_comb begin
    op_o = PKE_OP_OTHER;
    if (opcode_i[6:4] == 3'h0) begin
      case (opcode_i[3:0])
        `PKE_OPC_ADD: op_o = PKE_OP_ADD;
        `PKE_OPC_SUB: op_o = PKE_OP_SUB;
        `PKE_OPC_INV_ODD, `PKE_OPC_INV_EVEN: op_o = PKE_OP_INV;
        default: op_o = PKE_OP_OTHER;
      endcase
    end
  end

  // Sizes 2, 3 and 4 fall inside the range for either field
  assign size_ok_o = (size_i != 8'h00) &&
    (size_i <= `PKE_MAX_DWORDS);

endmodule

// ### pke_front.sv
// Register front end and launch control of the public key engine
`include "pke_defs.svh"

module pke_front
  import pke_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rdata_o,
  output logic irq_o,
  output logic core_start_o,
  output pke_cfg_t core_cfg_o,
  output pke_op_t core_op_o,
  input wire logic core_done_i,
  input wire logic core_rmodn_done_i,
  input wire logic core_not_inv_i
);

  logic [4:0] ptr_a_reg;
  logic [4:0] ptr_b_reg;
  logic [4:0] ptr_c_reg;
  logic recomp_reg;
  logic sign_b_reg;
  logic sign_a_reg;
  logic [7:0] size_reg;
  logic field_reg;
  logic [6:0] opcode_reg;
  logic busy_reg;
  logic not_inv_reg;
  logic [`PKE_IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`PKE_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [`PKE_IRQ_WIDTH-1:0] irq_stat_next;
  logic [31:0] rdata_next;
  pke_op_t op_dec;
  logic size_ok;
  logic wr_config;
  logic wr_command;
  logic start_req;
  logic launch;
  logic refused;
  logic finish;

  pke_op_decode u_decode (
    .opcode_i(opcode_reg),
    .size_i(size_reg),
    .op_o(op_dec),
    .size_ok_o(size_ok)
  );

  // Writes to settings are dropped while busy so a running job cannot tear
  assign wr_config = bus_wr_i && (bus_addr_i == `PKE_ADDR_CONFIG) &&
    !busy_reg;
  assign wr_command = bus_wr_i && (bus_addr_i == `PKE_ADDR_COMMAND) &&
    !busy_reg;
  assign start_req = bus_wr_i && (bus_addr_i == `PKE_ADDR_CONTROL) &&
    bus_wdata_i[`PKE_CTRL_START_BIT];
  assign launch = start_req && !busy_reg && size_ok;
  assign refused = start_req && !busy_reg && !size_ok;
  assign finish = busy_reg && core_done_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_a_reg <= 5'h00;
      ptr_b_reg <= 5'h00;
      ptr_c_reg <= 5'h00;
    end else if (wr_config) begin
      ptr_a_reg <= bus_wdata_i[`PKE_CFG_PTR_A_LSB +: 5];
      ptr_b_reg <= bus_wdata_i[`PKE_CFG_PTR_B_LSB +: 5];
      ptr_c_reg <= bus_wdata_i[`PKE_CFG_PTR_C_LSB +: 5];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sign_b_reg <= 1'b0;
      sign_a_reg <= 1'b0;
      size_reg <= 8'h00;
      field_reg <= 1'b0;
      opcode_reg <= 7'h00;
    end else if (wr_command) begin
      sign_b_reg <= bus_wdata_i[`PKE_CMD_SIGN_B_BIT];
      sign_a_reg <= bus_wdata_i[`PKE_CMD_SIGN_A_BIT];
      size_reg <= bus_wdata_i[`PKE_CMD_SIZE_LSB +: 8];
      field_reg <= bus_wdata_i[`PKE_CMD_FIELD_BIT];
      opcode_reg <= bus_wdata_i[`PKE_CMD_OP_LSB +: 7];
    end
  end

  // A fresh set request beats the engine's clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recomp_reg <= 1'b0;
    end else if (wr_command && bus_wdata_i[`PKE_CMD_RECOMP_BIT]) begin
      recomp_reg <= 1'b1;
    end else if (core_rmodn_done_i) begin
      recomp_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else if (launch) begin
      busy_reg <= 1'b1;
    end else if (finish) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_start_o <= 1'b0;
    end else begin
      core_start_o <= launch;
    end
  end

  // Snapshot at launch; the core never sees later register edits
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_cfg_o <= '0;
      core_op_o <= PKE_OP_OTHER;
    end else if (launch) begin
      core_cfg_o.operand_a_pointer <= ptr_a_reg;
      core_cfg_o.operand_b_pointer <= ptr_b_reg;
      core_cfg_o.result_pointer <= ptr_c_reg;
      core_cfg_o.recompute_r_mod_n <= recomp_reg;
      core_cfg_o.coef_b_negative <= sign_b_reg;
      core_cfg_o.coef_a_negative <= sign_a_reg;
      core_cfg_o.operand_size_dwords <= size_reg;
      core_cfg_o.binary_field <= field_reg;
      core_cfg_o.operation_code <= opcode_reg;
      core_op_o <= op_dec;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      not_inv_reg <= 1'b0;
    end else if (launch) begin
      not_inv_reg <= 1'b0;
    end else if (finish && core_op_o == PKE_OP_INV && core_not_inv_i) begin
      not_inv_reg <= 1'b1;
    end
  end

  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (bus_wr_i && bus_addr_i == `PKE_ADDR_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~bus_wdata_i[`PKE_IRQ_WIDTH-1:0];
    end
    if (finish) begin
      irq_stat_next[`PKE_IRQ_DONE_BIT] = 1'b1;
    end
    if (finish && core_op_o == PKE_OP_INV && core_not_inv_i) begin
      irq_stat_next[`PKE_IRQ_NOTINV_BIT] = 1'b1;
    end
    if (refused) begin
      irq_stat_next[`PKE_IRQ_REFUSED_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= '0;
    end else if (bus_wr_i && bus_addr_i == `PKE_ADDR_IRQ_MASK) begin
      irq_mask_reg <= bus_wdata_i[`PKE_IRQ_WIDTH-1:0];
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    rdata_next = `PKE_RESET_WORD;
    case (bus_addr_i)
      `PKE_ADDR_CONFIG: begin
        rdata_next[`PKE_CFG_PTR_A_LSB +: 5] = ptr_a_reg;
        rdata_next[`PKE_CFG_PTR_B_LSB +: 5] = ptr_b_reg;
        rdata_next[`PKE_CFG_PTR_C_LSB +: 5] = ptr_c_reg;
      end
      `PKE_ADDR_COMMAND: begin
        rdata_next[`PKE_CMD_RECOMP_BIT] = recomp_reg;
        rdata_next[`PKE_CMD_SIGN_B_BIT] = sign_b_reg;
        rdata_next[`PKE_CMD_SIGN_A_BIT] = sign_a_reg;
        rdata_next[`PKE_CMD_SIZE_LSB +: 8] = size_reg;
        rdata_next[`PKE_CMD_FIELD_BIT] = field_reg;
        rdata_next[`PKE_CMD_OP_LSB +: 7] = opcode_reg;
      end
      `PKE_ADDR_CONTROL: rdata_next[`PKE_CTRL_START_BIT] = busy_reg;
      `PKE_ADDR_STATUS: begin
        rdata_next[`PKE_STAT_BUSY_BIT] = busy_reg;
        rdata_next[`PKE_STAT_NOTINV_BIT] = not_inv_reg;
      end
      `PKE_ADDR_VERSION: rdata_next = `PKE_VERSION_VALUE;
      `PKE_ADDR_IRQ_STAT: rdata_next[`PKE_IRQ_WIDTH-1:0] = irq_stat_reg;
      `PKE_ADDR_IRQ_MASK: rdata_next[`PKE_IRQ_WIDTH-1:0] = irq_mask_reg;
      default: rdata_next = `PKE_RESET_WORD;
    endcase
  end

  // Data only in the cycle after the read strobe, zero elsewhere
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= `PKE_RESET_WORD;
    end else if (bus_rd_i) begin
      bus_rdata_o <= rdata_next;
    end else begin
      bus_rdata_o <= `PKE_RESET_WORD;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_start_pulse: assert property (
    launch |=> core_start_o && busy_reg ##1 !core_start_o)
    else $error("Launch did not give one start pulse");
  chk_start_ignored: assert property (
    busy_reg && start_req |=> !core_start_o)
    else $error("Start accepted while busy");
  chk_busy_drop: assert property (
    finish |=> !busy_reg ##1 !busy_reg || core_start_o)
    else $error("Busy not cleared after finish");
  chk_busy_hold: assert property (
    busy_reg && !core_done_i |=> busy_reg)
    else $error("Busy fell without finish");
  chk_cfg_frozen: assert property (
    busy_reg && !finish |=> $stable(ptr_a_reg) && $stable(size_reg) &&
      $stable(opcode_reg) && $stable(core_cfg_o))
    else $error("Settings changed while busy");
  chk_ptr_snapshot: assert property (
    launch |=> core_cfg_o.operand_a_pointer == $past(ptr_a_reg) &&
      core_cfg_o.result_pointer == $past(ptr_c_reg))
    else $error("Pointer snapshot wrong");
  chk_recomp_clear: assert property (
    core_rmodn_done_i && !(wr_command && bus_wdata_i[31]) |=> !recomp_reg)
    else $error("Recompute bit not cleared");
  chk_recomp_set: assert property (
    wr_command && bus_wdata_i[31] |=> recomp_reg)
    else $error("Recompute bit not set");
  chk_notinv_flag: assert property (
    finish && core_op_o == PKE_OP_INV && core_not_inv_i |=>
      not_inv_reg && irq_stat_reg[`PKE_IRQ_NOTINV_BIT])
    else $error("Not invertible flag missing");
  chk_read_slot: assert property (
    bus_rd_i && bus_addr_i == `PKE_ADDR_CONFIG |=>
      bus_rdata_o[31:21] == 11'h000 && bus_rdata_o[15:13] == 3'h0 &&
      bus_rdata_o[7:5] == 3'h0)
    else $error("Reserved config bits not zero");
  chk_irq_level: assert property (
    (irq_stat_reg & irq_mask_reg) != '0 && !(bus_wr_i &&
      (bus_addr_i == `PKE_ADDR_IRQ_STAT ||
       bus_addr_i == `PKE_ADDR_IRQ_MASK)) |=> irq_o)
    else $error("Interrupt level wrong");
  // Sticky status must be set by the hardware event itself
  chk_done_sticky: assert property (
    finish |=> irq_stat_reg[`PKE_IRQ_DONE_BIT])
    else $error("Done status not set");
  chk_refuse_size: assert property (
    refused |=> !busy_reg && !core_start_o &&
      irq_stat_reg[`PKE_IRQ_REFUSED_BIT])
    else $error("Bad operand size not refused");
  chk_add_decode: assert property (
    launch && opcode_reg == {3'h0, `PKE_OPC_ADD} |=> core_op_o == PKE_OP_ADD)
    else $error("Addition code not decoded");
  chk_sub_decode: assert property (
    launch && opcode_reg == {3'h0, `PKE_OPC_SUB} |=> core_op_o == PKE_OP_SUB)
    else $error("Subtraction code not decoded");
  chk_notinv_clear: assert property (
    launch |=> !not_inv_reg)
    else $error("Not invertible flag kept past launch");
  chk_read_idle: assert property (
    !bus_rd_i |=> bus_rdata_o == 32'h0)
    else $error("Read data outside its slot");

  cov_launch_done: cover property (launch ##[1:50] finish);
  cov_busy_start: cover property (busy_reg && start_req);
  cov_not_inv: cover property (finish && core_not_inv_i &&
    core_op_o == PKE_OP_INV);
  cov_refused: cover property (refused);

endmodule

// ### tb.sv
// Self-checking bench of the key engine register front end
`include "pke_defs.svh"

module tb
  import pke_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic done = 1'b0;
  logic rmodn = 1'b0;
  logic notinv = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic start;
  pke_cfg_t cfg_o;
  pke_op_t op_o;
  logic rd_seen = 1'b0;
  logic [31:0] rd_q[$];
  logic [35:0] go_q[$];
  logic [31:0] c;
  logic [31:0] m;
  logic [6:0] opc[5] = '{7'h01, 7'h02, 7'h06, 7'h09, 7'h11};
  pke_op_t opx[5] = '{PKE_OP_ADD, PKE_OP_SUB, PKE_OP_INV, PKE_OP_INV,
                      PKE_OP_OTHER};
  int mismatches = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  pke_front dut (
    .sys_clk_i(clk),
    .rst_n_i(rst_n),
    .bus_addr_i(addr),
    .bus_wdata_i(wdata),
    .bus_wr_i(wr),
    .bus_rd_i(rd),
    .bus_rdata_o(rdata),
    .irq_o(irq),
    .core_start_o(start),
    .core_cfg_o(cfg_o),
    .core_op_o(op_o),
    .core_done_i(done),
    .core_rmodn_done_i(rmodn),
    .core_not_inv_i(notinv)
  );

  task automatic chk(input string what, input logic [35:0] exp,
                     input logic [35:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expectation queued before the strobe so the monitor never runs dry
  task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic core_ev(input logic dn, input logic ni, input logic rm);
    @(posedge clk);
    done <= dn;
    notinv <= ni;
    rmodn <= rm;
    @(posedge clk);
    done <= 1'b0;
    notinv <= 1'b0;
    rmodn <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk);
    chk("irq", {35'h0, e}, {35'h0, irq});
  endtask

  always @(posedge clk) rd_seen <= rd;

  // Sampled mid-cycle, where read data and launch pulse have settled
  always @(negedge clk) begin
    if (rd_seen) begin
      if (rd_q.size() == 0) chk("read queue", 36'h0, 36'h1);
      else chk("read data", {4'h0, rd_q.pop_front()}, {4'h0, rdata});
    end else if (rst_n && rdata !== 32'h0) begin
      chk("idle read data", 36'h0, {4'h0, rdata});
    end
    if (start === 1'b1) begin
      if (go_q.size() == 0) chk("stray launch", 36'h0, 36'h1);
      else chk("launch", go_q.pop_front(), {cfg_o, op_o});
    end
  end

  initial begin
    void'($urandom(91));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(`PKE_ADDR_CONFIG + 32'(4 * i),
             i == 4 ? `PKE_VERSION_VALUE : 32'h0);
    end
    wr_reg(`PKE_ADDR_CONFIG, 32'hffffffff);
    rd_reg(`PKE_ADDR_CONFIG, 32'h001f1f1f);
    wr_reg(`PKE_ADDR_COMMAND, 32'h7fffffff);
    rd_reg(`PKE_ADDR_COMMAND, 32'h6000ffff);
    wr_reg(`PKE_ADDR_VERSION, 32'h0);
    wr_reg(`PKE_ADDR_STATUS, 32'hffffffff);
    rd_reg(`PKE_ADDR_VERSION, `PKE_VERSION_VALUE);
    rd_reg(`PKE_ADDR_STATUS, 32'h0);
    wr_reg(`PKE_ADDR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      c = $urandom;
      m = {1'b0, 2'($urandom), 13'h0, 8'(2 + i % 3), 1'($urandom), opc[i]};
      wr_reg(`PKE_ADDR_CONFIG, c);
      wr_reg(`PKE_ADDR_COMMAND, m);
      go_q.push_back({m[31:29], m[15:0], c[4:0], c[12:8], c[20:16],
                      opx[i]});
      wr_reg(`PKE_ADDR_CONTROL, 32'h1);
      rd_reg(`PKE_ADDR_STATUS, 32'h00010000);
      rd_reg(`PKE_ADDR_CONTROL, 32'h1);
      wr_reg(`PKE_ADDR_CONFIG, ~c);
      wr_reg(`PKE_ADDR_COMMAND, ~m);
      wr_reg(`PKE_ADDR_CONTROL, 32'h1);
      core_ev(1'b1, 1'b1, 1'b0);
      rd_reg(`PKE_ADDR_STATUS, opx[i] == PKE_OP_INV ? 32'h800 : 32'h0);
      rd_reg(`PKE_ADDR_CONTROL, 32'h0);
      rd_reg(`PKE_ADDR_CONFIG, c & 32'h001f1f1f);
      rd_reg(`PKE_ADDR_COMMAND, m);
      irq_is(1'b1);
      wr_reg(`PKE_ADDR_IRQ_STAT, 32'h7);
      irq_is(1'b0);
    end
    // Completion while idle must leave every flag alone
    core_ev(1'b1, 1'b1, 1'b0);
    rd_reg(`PKE_ADDR_IRQ_STAT, 32'h0);
    foreach (opc[k]) begin
      // Cleared each pass so every refused size must set it afresh
      wr_reg(`PKE_ADDR_IRQ_STAT, 32'h4);
      wr_reg(`PKE_ADDR_COMMAND, k == 0 ? 32'h0 : 32'h00000501);
      wr_reg(`PKE_ADDR_CONTROL, 32'h1);
      rd_reg(`PKE_ADDR_STATUS, 32'h0);
      rd_reg(`PKE_ADDR_IRQ_STAT, 32'h4);
      if (k == 1) break;
    end
    irq_is(1'b0);
    wr_reg(`PKE_ADDR_IRQ_MASK, 32'h4);
    irq_is(1'b1);
    wr_reg(`PKE_ADDR_IRQ_STAT, 32'h4);
    irq_is(1'b0);
    wr_reg(`PKE_ADDR_COMMAND, 32'h80000204);
    rd_reg(`PKE_ADDR_COMMAND, 32'h80000204);
    wr_reg(`PKE_ADDR_COMMAND, 32'h00000204);
    rd_reg(`PKE_ADDR_COMMAND, 32'h80000204);
    // Pointers still hold the last accepted configuration word
    go_q.push_back({3'b100, 16'h0204, c[4:0], c[12:8], c[20:16],
                    PKE_OP_OTHER});
    wr_reg(`PKE_ADDR_CONTROL, 32'h1);
    core_ev(1'b0, 1'b0, 1'b1);
    core_ev(1'b1, 1'b0, 1'b0);
    rd_reg(`PKE_ADDR_COMMAND, 32'h00000204);
    repeat (3) @(posedge clk);
    chk("pending", 36'h0, 36'(rd_q.size() + go_q.size()));
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
